/* rtl/pms_pkg.sv */
package pms_pkg;
   // ==========================================
   // power states
   typedef enum logic [1:0] {
      PMS_CACHE_OFF,
      PMS_NORMAL,
      PMS_SLEEP,
      PMS_STOP
   } pms_state_t;

   // ==========================================
   // reset values
   localparam logic PMS_CACHE_EN_RST    = 1'b0;
   localparam logic PMS_SENSE_AMP_RST   = 1'b0;
   localparam logic PMS_PWR_DOWN_RST    = 1'b0;
   localparam logic PMS_REFRESH_REQ_RST = 1'b0;
   localparam logic PMS_BUS_OE_RST      = 1'b1;
   localparam logic PMS_CORE_CLK_EN_RST = 1'b1;
   localparam logic PMS_PLL_EN_RST      = 1'b1;

   // ==========================================
   // timing
   localparam int   PMS_CLK_PERIOD_NS   = 10;
   localparam int   PMS_GATE_DELAY_CYC  = 1;
endpackage : pms_pkg

/* rtl/pms_sw_if.sv */
`timescale 1ns/1ps
interface pms_sw_if;
   logic cacheWrite;   // write strobe to cache_control_reg
   logic cacheEnable;  // written enable value
   logic sleepWrite;   // write strobe to sleep mode register
   logic cacheWrOk;    // cache write strobe, passed on in every state
   logic sleepWrOk;    // sleep write qualified for current state

   modport src (output cacheWrite, cacheEnable, sleepWrite, input cacheWrOk, sleepWrOk);
   modport dec (input cacheWrite, cacheEnable, sleepWrite, output cacheWrOk, sleepWrOk);
endinterface : pms_sw_if

/* rtl/pms_pin_qual.sv */
`timescale 1ns/1ps
module pms_pin_qual (
   input  wire pms_pkg::pms_state_t stateIn,    // current power state
   input  wire logic                wakeInN,    // wake pin, active low
   input  wire logic                stopInN,    // stop pin, active low
   output logic                     wakeHit,    // wake accepted
   output logic                     stopHit     // stop accepted
);
   import pms_pkg::*;
   wire inSleep = (stateIn == PMS_SLEEP);
   assign wakeHit = inSleep && !wakeInN;
   assign stopHit = inSleep && !stopInN && wakeInN;
endmodule : pms_pin_qual

/* rtl/power_mode_sequencer.sv */
`timescale 1ns/1ps
module power_mode_sequencer (
   input  wire logic           clk,              // core clock
   input  wire logic           arst_n,           // async reset, active low
   input  wire logic           clkEn,            // clock enable
   input  wire logic           cacheWrite,       // cache_control_reg write strobe
   input  wire logic           cacheEnable,      // written cache enable bit
   input  wire logic           sleepWrite,       // sleep mode register write strobe
   input  wire logic           wake_in_n,        // wake pin, active low
   input  wire logic           stopInN,          // stop pin, active low
   output pms_pkg::pms_state_t stateOut,         // current power state
   output logic                cacheOn,          // caches enabled
   output logic                senseAmpOn,       // cache sense amp power
   output logic                power_down_out,   // power-down pin
   output logic                selfRefreshReq,   // sdram self-refresh request pulse
   output logic                coreClkEn,        // core/peripheral clock enable
   output logic                pllEn,            // pll run enable
   output logic                busOe             // external bus drive enable
);
   import pms_pkg::*;

   // ==========================================
   // software request decode
   pms_sw_if sw ();
   assign sw.cacheWrite  = cacheWrite;
   assign sw.cacheEnable = cacheEnable;
   assign sw.sleepWrite  = sleepWrite;

   pms_state_t state_r;
   pms_state_t state_nxt;
   logic       cacheOn_r;
   logic       senseAmpOn_r;
   logic       pwrDown_r;
   logic       selfRefresh_r;
   logic       busOe_r;
   logic       coreClkEn_r;
   logic       pllEn_r;

   assign sw.cacheWrOk = sw.cacheWrite;
   assign sw.sleepWrOk = sw.sleepWrite && (state_r == PMS_CACHE_OFF) && !sw.cacheWrite;

   wire wakeHit;
   wire stopHit;
   pms_pin_qual pms_pin_qual_inst (
      .stateIn (state_r),
      .wakeInN (wake_in_n),
      .stopInN (stopInN),
      .wakeHit (wakeHit),
      .stopHit (stopHit)
   );

   wire enCache  = sw.cacheWrOk && sw.cacheEnable;
   wire disCache = sw.cacheWrOk && !sw.cacheEnable;

   // ==========================================
   // next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         PMS_CACHE_OFF: begin
            if (enCache) begin
               state_nxt = PMS_NORMAL;
            end else if (sw.sleepWrOk) begin
               state_nxt = PMS_SLEEP;
            end
         end
         PMS_NORMAL: begin
            if (disCache) begin
               state_nxt = PMS_CACHE_OFF;
            end
         end
         PMS_SLEEP: begin
            if (wakeHit) begin
               state_nxt = PMS_CACHE_OFF;
            end else if (stopHit) begin
               state_nxt = PMS_STOP;
            end
         end
         default: begin
            state_nxt = PMS_STOP;
         end
      endcase
   end

   // ==========================================
   // state register; only normal entry is from cache-off
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= PMS_CACHE_OFF;
      end else if (clkEn) begin
         state_r <= state_nxt;
      end
   end

   // ==========================================
   // output next values; refresh goes out on sleep entry, core clock gates one cycle later
   wire enterSleep      = (state_r == PMS_CACHE_OFF) && (state_nxt == PMS_SLEEP);
   wire nxtNormal       = (state_nxt == PMS_NORMAL);
   wire nxtSleep        = (state_nxt == PMS_SLEEP);
   wire nxtStop         = (state_nxt == PMS_STOP);
   wire cacheOn_nxt     = nxtNormal;
   wire senseAmpOn_nxt  = nxtNormal;
   wire pwrDown_nxt     = nxtSleep;
   wire selfRefresh_nxt = enterSleep;
   wire busOe_nxt       = !nxtSleep && !nxtStop;
   wire coreClkEn_nxt   = (!nxtSleep && !nxtStop) || enterSleep;
   wire pllEn_nxt       = !nxtStop;

   // ==========================================
   // output registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cacheOn_r     <= PMS_CACHE_EN_RST;
         senseAmpOn_r  <= PMS_SENSE_AMP_RST;
         pwrDown_r     <= PMS_PWR_DOWN_RST;
         selfRefresh_r <= PMS_REFRESH_REQ_RST;
         busOe_r       <= PMS_BUS_OE_RST;
         coreClkEn_r   <= PMS_CORE_CLK_EN_RST;
         pllEn_r       <= PMS_PLL_EN_RST;
      end else if (clkEn) begin
         cacheOn_r     <= cacheOn_nxt;
         senseAmpOn_r  <= senseAmpOn_nxt;
         pwrDown_r     <= pwrDown_nxt;
         selfRefresh_r <= selfRefresh_nxt;
         busOe_r       <= busOe_nxt;
         coreClkEn_r   <= coreClkEn_nxt;
         pllEn_r       <= pllEn_nxt;
      end
   end

   // ==========================================
   // port drive
   assign stateOut       = state_r;
   assign cacheOn        = cacheOn_r;
   assign senseAmpOn     = senseAmpOn_r;
   assign power_down_out = pwrDown_r;
   assign selfRefreshReq = selfRefresh_r;
   assign busOe          = busOe_r;
   assign coreClkEn      = coreClkEn_r;
   assign pllEn          = pllEn_r;

   // ==========================================
   // checks
   property p_rst_state;
      @(posedge clk) $rose(arst_n) |-> (state_r == PMS_CACHE_OFF) && !cacheOn;
   endproperty
   a_rst_state: assert property (p_rst_state) else $error("not cache-off after reset");

   property p_amp_off;
      @(posedge clk) disable iff (!arst_n) (state_r == PMS_CACHE_OFF) && $stable(state_r) |-> !senseAmpOn;
   endproperty
   a_amp_off: assert property (p_amp_off) else $error("sense amp on in cache-off");

   property p_to_normal;
      @(posedge clk) disable iff (!arst_n)
         clkEn && state_r == PMS_CACHE_OFF && cacheWrite && cacheEnable |=> state_r == PMS_NORMAL ##0 cacheOn;
   endproperty
   a_to_normal: assert property (p_to_normal) else $error("cache enable did not reach normal");

   property p_normal_src;
      @(posedge clk) disable iff (!arst_n)
         $changed(state_r) && state_r == PMS_NORMAL |-> $past(state_r) == PMS_CACHE_OFF;
   endproperty
   a_normal_src: assert property (p_normal_src) else $error("normal entered from wrong state");

   property p_to_off;
      @(posedge clk) disable iff (!arst_n)
         clkEn && state_r == PMS_NORMAL && cacheWrite && !cacheEnable |=> state_r == PMS_CACHE_OFF;
   endproperty
   a_to_off: assert property (p_to_off) else $error("cache disable did not return cache-off");

   property p_to_sleep;
      @(posedge clk) disable iff (!arst_n)
         clkEn && state_r == PMS_CACHE_OFF && sleepWrite && !cacheWrite |=> state_r == PMS_SLEEP;
   endproperty
   a_to_sleep: assert property (p_to_sleep) else $error("sleep write did not sleep");

   property p_sleep_src;
      @(posedge clk) disable iff (!arst_n)
         $changed(state_r) && state_r == PMS_SLEEP |-> $past(state_r) == PMS_CACHE_OFF;
   endproperty
   a_sleep_src: assert property (p_sleep_src) else $error("sleep entered from wrong state");

   property p_power_down_out;
      @(posedge clk) disable iff (!arst_n) power_down_out == (state_r == PMS_SLEEP);
   endproperty
   a_power_down_out: assert property (p_power_down_out) else $error("power-down output mismatch");

   property p_refresh_first;
      @(posedge clk) disable iff (!arst_n)
         clkEn && $changed(state_r) && state_r == PMS_SLEEP |-> selfRefreshReq && coreClkEn;
   endproperty
   a_refresh_first: assert property (p_refresh_first) else $error("clocks gated before refresh");

   property p_bus_free;
      @(posedge clk) disable iff (!arst_n) state_r == PMS_SLEEP |-> !busOe;
   endproperty
   a_bus_free: assert property (p_bus_free) else $error("bus driven in sleep");

   property p_wake;
      @(posedge clk) disable iff (!arst_n)
         clkEn && state_r == PMS_SLEEP && !wake_in_n |=> state_r == PMS_CACHE_OFF;
   endproperty
   a_wake: assert property (p_wake) else $error("wake did not return cache-off");

   property p_stop;
      @(posedge clk) disable iff (!arst_n)
         clkEn && state_r == PMS_SLEEP && wake_in_n && !stopInN |=> state_r == PMS_STOP ##0 !pllEn;
   endproperty
   a_stop: assert property (p_stop) else $error("stop pin did not stop");

   property p_stop_src;
      @(posedge clk) disable iff (!arst_n)
         $changed(state_r) && state_r == PMS_STOP |-> $past(state_r) == PMS_SLEEP;
   endproperty
   a_stop_src: assert property (p_stop_src) else $error("stop entered from wrong state");

   property p_stop_hold;
      @(posedge clk) disable iff (!arst_n) state_r == PMS_STOP |=> state_r == PMS_STOP;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");

   property p_clk_gate;
      @(posedge clk) disable iff (!arst_n) state_r == PMS_SLEEP && !selfRefreshReq |-> !coreClkEn && pllEn;
   endproperty
   a_clk_gate: assert property (p_clk_gate) else $error("clocks not gated in sleep");

   property p_stop_clocks;
      @(posedge clk) disable iff (!arst_n) state_r == PMS_STOP |-> !pllEn && !coreClkEn && !busOe;
   endproperty
   a_stop_clocks: assert property (p_stop_clocks) else $error("clock running in stop");

   property p_cache_flags;
      @(posedge clk) disable iff (!arst_n) cacheOn == (state_r == PMS_NORMAL) && senseAmpOn == cacheOn;
   endproperty
   a_cache_flags: assert property (p_cache_flags) else $error("cache flags disagree with state");

   property p_wake_resume;
      @(posedge clk) disable iff (!arst_n)
         clkEn && state_r == PMS_SLEEP && !wake_in_n |=> coreClkEn && busOe && !power_down_out && !cacheOn;
   endproperty
   a_wake_resume: assert property (p_wake_resume) else $error("no clean resume after wake");

   property p_both_pins;
      @(posedge clk) disable iff (!arst_n)
         clkEn && state_r == PMS_SLEEP && !wake_in_n && !stopInN |=> state_r == PMS_CACHE_OFF && pllEn;
   endproperty
   a_both_pins: assert property (p_both_pins) else $error("stop beat wake");

   property p_stop_ignored;
      @(posedge clk) disable iff (!arst_n)
         clkEn && (state_r == PMS_CACHE_OFF || state_r == PMS_NORMAL) && !stopInN |=> state_r != PMS_STOP;
   endproperty
   a_stop_ignored: assert property (p_stop_ignored) else $error("stop pin taken outside sleep");

   property p_no_sleep_normal;
      @(posedge clk) disable iff (!arst_n)
         clkEn && state_r == PMS_NORMAL && sleepWrite |=> state_r != PMS_SLEEP;
   endproperty
   a_no_sleep_normal: assert property (p_no_sleep_normal) else $error("sleep entered from normal");

   property p_normal_exit;
      @(posedge clk) disable iff (!arst_n)
         clkEn && state_r == PMS_NORMAL && !(cacheWrite && !cacheEnable) |=> state_r == PMS_NORMAL;
   endproperty
   a_normal_exit: assert property (p_normal_exit) else $error("normal left without disable write");

   property p_cacheoff_hold;
      @(posedge clk) disable iff (!arst_n)
         clkEn && state_r == PMS_CACHE_OFF && !cacheWrite && !sleepWrite |=> state_r == PMS_CACHE_OFF;
   endproperty
   a_cacheoff_hold: assert property (p_cacheoff_hold) else $error("cache-off left without write");

   property p_sleep_hold;
      @(posedge clk) disable iff (!arst_n)
         clkEn && state_r == PMS_SLEEP && wake_in_n && stopInN |=> state_r == PMS_SLEEP && power_down_out;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("sleep or power-down dropped");

   property p_refresh_once;
      @(posedge clk) disable iff (!arst_n) clkEn && selfRefreshReq |=> !selfRefreshReq;
   endproperty
   a_refresh_once: assert property (p_refresh_once) else $error("refresh request too long");
endmodule : power_mode_sequencer

/* tb/pms_pin_partner.sv */
`timescale 1ns/1ps
module pms_pin_partner (
   input  wire logic wakeReq,  // ask for wake
   input  wire logic stopReq,  // ask for stop
   input  wire logic rstReq,   // ask for system reset
   output logic      wakeN,    // wake pin, active low
   output logic      stopN,    // stop pin, active low
   output logic      arstN     // system reset, active low
);
   // ==========================================
   // pins rest high and go low while asserted
   assign wakeN = ~wakeReq;
   assign stopN = ~stopReq;
   assign arstN = ~rstReq;
endmodule : pms_pin_partner

/* tb/tb_power_mode_sequencer.sv */
`timescale 1ns/1ps
module tb_power_mode_sequencer;
   import pms_pkg::*;
   logic       clk = 1'b0;
   logic       clkEn = 1'b1;
   logic       cacheWrite = 1'b0;
   logic       cacheEnable = 1'b0;
   logic       sleepWrite = 1'b0;
   logic       wakeReq = 1'b0;
   logic       stopReq = 1'b0;
   logic       rstReq = 1'b1;
   logic       wakeN, stopN, arstN;
   pms_state_t stateOut;
   logic       cacheOn, senseAmpOn, powerDown, selfRefreshReq, coreClkEn, pllEn, busOe;
   int         failures = 0;
   int         total_checks = 0;

   always #(PMS_CLK_PERIOD_NS / 2) clk = ~clk;

   pms_pin_partner pms_pin_partner_inst (.wakeReq(wakeReq), .stopReq(stopReq), .rstReq(rstReq),
      .wakeN(wakeN), .stopN(stopN), .arstN(arstN));
   power_mode_sequencer power_mode_sequencer_inst (.clk(clk), .arst_n(arstN), .clkEn(clkEn),
      .cacheWrite(cacheWrite), .cacheEnable(cacheEnable), .sleepWrite(sleepWrite), .wake_in_n(wakeN),
      .stopInN(stopN), .stateOut(stateOut), .cacheOn(cacheOn), .senseAmpOn(senseAmpOn),
      .power_down_out(powerDown), .selfRefreshReq(selfRefreshReq), .coreClkEn(coreClkEn),
      .pllEn(pllEn), .busOe(busOe));

   // ==========================================
   // compare and drive helpers
   task automatic chk(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask : chk

   task automatic chkSt(input pms_state_t exp);
      total_checks++;
      if (stateOut !== exp) begin
         failures++;
         $display("MISMATCH stateOut expected %0d seen %0d", exp, stateOut);
      end
   endtask : chkSt

   task automatic expectAll(input pms_state_t st, input logic co, sa, pd, bo, ce, pe);
      chkSt(st);
      chk("cacheOn", co, cacheOn);
      chk("senseAmpOn", sa, senseAmpOn);
      chk("power_down_out", pd, powerDown);
      chk("busOe", bo, busOe);
      chk("coreClkEn", ce, coreClkEn);
      chk("pllEn", pe, pllEn);
   endtask : expectAll

   // one-cycle request, outputs judged just after the edge that takes it
   task automatic apply(input logic cw, ce, sw, wk, st);
      @(posedge clk);
      cacheWrite  <= cw;
      cacheEnable <= ce;
      sleepWrite  <= sw;
      wakeReq     <= wk;
      stopReq     <= st;
      @(posedge clk);
      cacheWrite <= 1'b0;
      sleepWrite <= 1'b0;
      wakeReq    <= 1'b0;
      stopReq    <= 1'b0;
      #1;
   endtask : apply

   // ==========================================
   // scenarios
   task automatic t_reset;
      expectAll(PMS_CACHE_OFF, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      apply(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      expectAll(PMS_CACHE_OFF, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      $display("test reset done");
   endtask : t_reset

   task automatic t_normal;
      apply(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);  // flush done first
      expectAll(PMS_NORMAL, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      apply(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      expectAll(PMS_NORMAL, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      @(posedge clk);
      clkEn       <= 1'b0;
      cacheWrite  <= 1'b1;
      cacheEnable <= 1'b0;
      @(posedge clk);
      clkEn      <= 1'b1;
      cacheWrite <= 1'b0;
      #1;
      expectAll(PMS_NORMAL, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      apply(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      expectAll(PMS_CACHE_OFF, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      apply(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      chkSt(PMS_NORMAL);
      apply(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      chkSt(PMS_CACHE_OFF);
      $display("test normal done");
   endtask : t_normal

   task automatic t_sleep;
      apply(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);  // caches already off
      expectAll(PMS_SLEEP, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
      chk("selfRefreshReq", 1'b1, selfRefreshReq);
      repeat (PMS_GATE_DELAY_CYC) @(posedge clk);
      #1;
      chk("selfRefreshReq", 1'b0, selfRefreshReq);
      expectAll(PMS_SLEEP, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      apply(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      expectAll(PMS_SLEEP, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      apply(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      expectAll(PMS_CACHE_OFF, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      $display("test sleep done");
   endtask : t_sleep

   task automatic t_stop;
      apply(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      apply(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
      chkSt(PMS_CACHE_OFF);
      apply(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      apply(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      expectAll(PMS_STOP, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      apply(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
      expectAll(PMS_STOP, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      @(posedge clk);
      rstReq <= 1'b1;
      repeat (2) @(posedge clk);
      rstReq <= 1'b0;
      @(posedge clk);
      #1;
      expectAll(PMS_CACHE_OFF, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      $display("test stop done");
   endtask : t_stop

   // ==========================================
   // verdict
   task automatic summarize;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (10) @(posedge clk);
      rstReq <= 1'b0;
      @(posedge clk);
      #1;
      t_reset;
      t_normal;
      t_sleep;
      t_stop;
      summarize;
   end

   initial begin
      repeat (1000) @(posedge clk);
      failures++;
      summarize;
   end
endmodule : tb_power_mode_sequencer
